/* inc/tcde_pkg.sv */
package tcde_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W    = 16;            // Data space address width
  localparam int NCH       = 2;             // Channel count
  localparam int BURST_MAX = 8;             // Longest burst in bytes
  localparam int BIDX_W    = 3;             // Burst buffer index width
  localparam int BLEN_W    = 4;             // Burst length counter width
  localparam int BLK_W     = 17;            // Block counter, holds 64K
  localparam int RPT_W     = 9;             // Repeat counter, holds 256

  // ----------------------------------------------------------------
  // Data memory map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] EE_BASE   = 16'h1000; // Mapped storage window
  localparam logic [ADDR_W-1:0] SRAM_BASE = 16'h2000; // First SRAM byte
  localparam logic [ADDR_W-1:0] SRAM_MID  = 16'h6000; // Second SRAM section

  // Section codes, one per separately accessed memory set
  localparam logic [1:0] SECT_IO   = 2'h0;
  localparam logic [1:0] SECT_EE   = 2'h1;
  localparam logic [1:0] SECT_SRLO = 2'h2;
  localparam logic [1:0] SECT_SRHI = 2'h3;

  // ----------------------------------------------------------------
  // Access timing in clock cycles
  // ----------------------------------------------------------------
  localparam logic [1:0] LAT_IO       = 2'h1; // Any I/O access
  localparam logic [1:0] LAT_SR_FIRST = 2'h2; // Single SRAM read
  localparam logic [1:0] LAT_SR_NEXT  = 2'h1; // Following byte of a burst
  localparam logic [1:0] LAT_EE_FIRST = 2'h3; // Single storage read
  localparam logic [1:0] LAT_EE_NEXT  = 2'h2; // Following byte of a burst

  // ----------------------------------------------------------------
  // Mode encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] AM_FIXED = 2'h0;   // Address held
  localparam logic [1:0] AM_INC   = 2'h1;   // Up one per byte
  localparam logic [1:0] AM_DEC   = 2'h2;   // Down one per byte

  localparam logic [1:0] RL_NONE  = 2'h0;   // Never restore
  localparam logic [1:0] RL_BLOCK = 2'h1;   // Restore at block end
  localparam logic [1:0] RL_BURST = 2'h2;   // Restore at burst end
  localparam logic [1:0] RL_TRANS = 2'h3;   // Restore at transaction end

  localparam logic [1:0] TRG_SW   = 2'h0;   // Software request
  localparam logic [1:0] TRG_PER  = 2'h1;   // Peripheral request
  localparam logic [1:0] TRG_EV   = 2'h2;   // Event pulse

  // ----------------------------------------------------------------
  // Per channel configuration
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] srcStart;  // Programmed source start
    logic [ADDR_W-1:0] dstStart;  // Programmed destination start
    logic [15:0]       blkSize;   // Block bytes, zero means 64K
    logic [7:0]        rptCnt;    // Blocks per transaction, zero means 256
    logic [1:0]        srcMode;   // Source address mode
    logic [1:0]        dstMode;   // Destination address mode
    logic [1:0]        srcReload; // Source reload point
    logic [1:0]        dstReload; // Destination reload point
    logic [1:0]        burstSel;  // Burst of 1, 2, 4 or 8 bytes
    logic [1:0]        trigSel;   // Trigger source
    logic              crcEn;     // Feed bytes to checksum unit
    logic              doneIrqEn; // Completion request enable
    logic              errIrqEn;  // Error request enable
  } tcde_cfg_t;

endpackage : tcde_pkg

/* logic/tcde_burst_buf.sv */
`timescale 1ns/100ps

// Small burst store: one write port, registered read data
module tcde_burst_buf #(
  parameter int W  = 8,   // Data width
  parameter int D  = 8,   // Depth in words
  parameter int AW = 3    // Address width
) (
  input  wire logic          clk_sys,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [W-1:0]  wrData,
  input  wire logic [AW-1:0] rdAddr,
  output logic      [W-1:0]  rdData_q
);

  logic [W-1:0] mem [D];    // Storage array, no reset needed

  // ----------------------------------------------------------------
  // Write and registered read
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
    rdData_q <= mem[rdAddr];  // Old data on a same-address write
  end

endmodule : tcde_burst_buf

/* logic/tcde_engine.sv */
`timescale 1ns/100ps

module tcde_engine
  import tcde_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  tcde_cfg_t [NCH-1:0]        chCfg,
  input  wire logic [NCH-1:0]        chStart,
  input  wire logic [NCH-1:0]        swTrig,
  input  wire logic [NCH-1:0]        perReq,
  input  wire logic [NCH-1:0]        evIn,
  input  wire logic                  prioRr,
  input  wire logic                  linkEn,
  output logic                       rdReq,
  output logic      [ADDR_W-1:0]     rdAddr,
  output logic      [1:0]            rdSect,
  input  wire logic                  rdGnt,
  input  wire logic [7:0]            rdData,
  input  wire logic                  rdErr,
  output logic                       wrReq,
  output logic      [ADDR_W-1:0]     wrAddr,
  output logic      [1:0]            wrSect,
  output logic      [7:0]            wrData,
  input  wire logic                  wrGnt,
  input  wire logic                  wrErr,
  output logic                       crcValid,
  output logic      [7:0]            crcData,
  output logic      [NCH-1:0]        chBusy,
  output logic      [NCH-1:0]        doneIrq,
  output logic      [NCH-1:0]        errIrq
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Memory section of an address
  function automatic logic [1:0] sectOf(input logic [ADDR_W-1:0] a);
    if (a < EE_BASE)
      return SECT_IO;
    else if (a < SRAM_BASE)
      return SECT_EE;
    else if (a < SRAM_MID)
      return SECT_SRLO;
    else
      return SECT_SRHI;
  endfunction : sectOf

  // Read latency by section and position in the burst
  function automatic logic [1:0] latOf(input logic [1:0] s, input logic first);
    if (s == SECT_IO)
      return LAT_IO;
    else if (s == SECT_EE)
      return first ? LAT_EE_FIRST : LAT_EE_NEXT;
    else
      return first ? LAT_SR_FIRST : LAT_SR_NEXT;
  endfunction : latOf

  // Address after one byte
  function automatic logic [ADDR_W-1:0] nextAddr(input logic [ADDR_W-1:0] a,
                                                 input logic [1:0] m);
    if (m == AM_INC)
      return a + 16'h0001;
    else if (m == AM_DEC)
      return a - 16'h0001;
    else
      return a;
  endfunction : nextAddr

  // Whether a reload point is reached
  function automatic logic reloadHit(input logic [1:0] m, input logic blk, input logic tr);
    return (m == RL_BURST) | ((m == RL_BLOCK) & blk) | ((m == RL_TRANS) & tr);
  endfunction : reloadHit

  // ----------------------------------------------------------------
  // Engine state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE,     // Waiting for a pending channel
    S_READ,     // Filling the burst buffer
    S_PREP,     // Buffer read latency
    S_WRITE     // Draining the buffer
  } tcde_state_t;

  tcde_state_t        state_q;      // Current state
  tcde_state_t        state_d;      // Next state
  logic               ch_q;         // Channel owning the datapath
  logic               lastCh_q;     // Last granted channel
  logic [BLEN_W-1:0]  burstN_q;     // Bytes in this burst
  logic [BLEN_W-1:0]  idx_q;        // Byte index in burst
  logic [1:0]         rdCnt_q;      // Granted read cycles so far
  logic               crcValid_q;   // Checksum strobe
  logic [7:0]         crcData_q;    // Checksum byte
  logic [NCH-1:0]     doneIrq_q;    // Completion pulse
  logic [NCH-1:0]     errIrq_q;     // Error pulse
  logic [7:0]         bufQ;         // Buffer read data

  // Per channel state, gathered from the channel slices
  logic [ADDR_W-1:0]  srcCur [NCH];
  logic [ADDR_W-1:0]  dstCur [NCH];
  logic [BLK_W-1:0]   blkRem [NCH];
  logic [RPT_W-1:0]   rptRem [NCH];
  logic [NCH-1:0]     armed;
  logic [NCH-1:0]     pend;

  // ----------------------------------------------------------------
  // Datapath decode
  // ----------------------------------------------------------------
  tcde_cfg_t          cfgA;         // Active channel settings
  wire logic          busy      = (state_q != S_IDLE);
  wire logic          inRead    = (state_q == S_READ);
  wire logic          inWrite   = (state_q == S_WRITE);
  wire logic [1:0]    srcSect   = sectOf(srcCur[ch_q]);
  wire logic [1:0]    dstSect   = sectOf(dstCur[ch_q]);
  wire logic [1:0]    lat       = latOf(srcSect, idx_q == 4'h0);
  wire logic [BLEN_W-1:0] lastIdx = burstN_q - 4'h1;

  assign cfgA = chCfg[ch_q];

  // A byte is captured only on the granted cycle that ends its latency
  wire logic rdFire   = inRead & rdGnt & (rdCnt_q == lat - 2'h1);
  wire logic wrFire   = inWrite & wrGnt;
  wire logic lastRd   = rdFire & (idx_q == lastIdx);
  wire logic burstEnd = wrFire & (idx_q == lastIdx);
  wire logic blkEnd   = burstEnd & (blkRem[ch_q] == {13'h0000, burstN_q});
  wire logic trEnd    = blkEnd & (rptRem[ch_q] == 9'h001);
  wire logic busErr   = (inRead & rdErr) | (inWrite & wrErr);

  // ----------------------------------------------------------------
  // Channel selection
  // ----------------------------------------------------------------
  wire logic [NCH-1:0] ready = armed & pend;
  wire logic           both  = &ready;
  // Alternating mode hands a tie to the channel not served last
  wire logic pickCh  = both ? (prioRr & ~lastCh_q) : ready[1];
  wire logic pickGo  = ~busy & (|ready);

  // Burst length, cut short by what is left of the block
  wire logic [BLEN_W-1:0] selBytes = 4'h1 << chCfg[pickCh].burstSel;
  wire logic [BLK_W-1:0]  pickRem  = blkRem[pickCh];
  wire logic [BLEN_W-1:0] pickN    = (pickRem < {13'h0000, selBytes}) ?
                                     pickRem[BLEN_W-1:0] : selBytes;

  // ----------------------------------------------------------------
  // Channel slices
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    logic [ADDR_W-1:0] src_q;       // Current source address
    logic [ADDR_W-1:0] dst_q;       // Current destination address
    logic [BLK_W-1:0]  blk_q;       // Bytes left in block
    logic [RPT_W-1:0]  rpt_q;       // Blocks left in transaction
    logic              armed_q;     // Transaction open
    logic              pend_q;      // Trigger waiting

    tcde_cfg_t         cfg;
    assign cfg = chCfg[i];

    // Start values, zero sizes stand for the largest
    wire logic [BLK_W-1:0] blkInit = (cfg.blkSize == 16'h0000) ? 17'h10000 : {1'b0, cfg.blkSize};
    wire logic [RPT_W-1:0] rptInit = (cfg.rptCnt == 8'h00) ? 9'h100 : {1'b0, cfg.rptCnt};

    wire logic act     = busy & (ch_q == i);
    // The partner finishing re-opens this channel when linked
    wire logic kick    = linkEn & busy & (ch_q != i) & trEnd;
    wire logic armNow  = ~armed_q & (chStart[i] | kick);
    wire logic trigHit = armed_q & (((cfg.trigSel == TRG_SW) & swTrig[i]) |
                                    ((cfg.trigSel == TRG_PER) & perReq[i]) |
                                    ((cfg.trigSel == TRG_EV) & evIn[i]));
    // Hardware triggers allow one burst, software runs to the end
    wire logic pendClr = (pickGo & (pickCh == i) & (cfg.trigSel != TRG_SW)) |
                         (act & (trEnd | busErr));
    wire logic srcRl   = act & burstEnd & reloadHit(cfg.srcReload, blkEnd, trEnd);
    wire logic dstRl   = act & burstEnd & reloadHit(cfg.dstReload, blkEnd, trEnd);

    // Open, trigger and close bookkeeping
    always_ff @(posedge clk_sys)
    begin
      if (!rst_b)
      begin
        armed_q <= 1'b0;
        pend_q  <= 1'b0;
      end
      else
      begin
        armed_q <= armNow | (armed_q & ~(act & (trEnd | busErr)));
        // A new trigger wins over a clear in the same cycle
        pend_q  <= trigHit | (armNow & kick) | (pend_q & ~pendClr);
      end
    end

    // Source address walk and reload
    always_ff @(posedge clk_sys)
    begin
      if (!rst_b)
        src_q <= '0;
      else if (armNow)
        src_q <= cfg.srcStart;
      else if (srcRl)
        src_q <= cfg.srcStart;
      else if (act & rdFire)
        src_q <= nextAddr(src_q, cfg.srcMode);
    end

    // Destination address walk and reload
    always_ff @(posedge clk_sys)
    begin
      if (!rst_b)
        dst_q <= '0;
      else if (armNow)
        dst_q <= cfg.dstStart;
      else if (dstRl)
        dst_q <= cfg.dstStart;
      else if (act & wrFire)
        dst_q <= nextAddr(dst_q, cfg.dstMode);
    end

    // Block and repeat counters
    always_ff @(posedge clk_sys)
    begin
      if (!rst_b)
      begin
        blk_q <= '0;
        rpt_q <= '0;
      end
      else if (armNow)
      begin
        blk_q <= blkInit;
        rpt_q <= rptInit;
      end
      else if (act & blkEnd)
      begin
        blk_q <= blkInit;
        rpt_q <= rpt_q - 9'h001;
      end
      else if (act & burstEnd)
      begin
        blk_q <= blk_q - {13'h0000, burstN_q};
      end
    end

    assign srcCur[i] = src_q;
    assign dstCur[i] = dst_q;
    assign blkRem[i] = blk_q;
    assign rptRem[i] = rpt_q;
    assign armed[i]  = armed_q;
    assign pend[i]   = pend_q;
  end : g_ch

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------

  // Next state: read burst, one buffer latency cycle, write burst
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE:
        if (pickGo)
          state_d = S_READ;
      S_READ:
        if (busErr)
          state_d = S_IDLE;
        else if (lastRd)
          state_d = S_PREP;
      S_PREP:
        state_d = S_WRITE;
      S_WRITE:
        if (busErr | burstEnd)
          state_d = S_IDLE;
    endcase
  end

  // State and channel ownership
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state_q  <= S_IDLE;
      ch_q     <= 1'b0;
      lastCh_q <= 1'b1;
      burstN_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (pickGo)
      begin
        ch_q     <= pickCh;
        lastCh_q <= pickCh;
        burstN_q <= pickN;
      end
    end
  end

  // Byte index and read latency count; no grant, no progress
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      idx_q   <= '0;
      rdCnt_q <= '0;
    end
    else
    begin
      if (pickGo | lastRd)
        idx_q <= '0;
      else if (rdFire | wrFire)
        idx_q <= idx_q + 4'h1;
      if (rdFire | ~inRead)
        rdCnt_q <= '0;
      else if (rdGnt)
        rdCnt_q <= rdCnt_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Burst buffer
  // ----------------------------------------------------------------

  // Read address runs one byte ahead while writes are accepted
  wire logic [BIDX_W-1:0] bufRa = inWrite ? (wrFire ? idx_q[BIDX_W-1:0] + 3'h1 : idx_q[BIDX_W-1:0])
                                          : '0;

  tcde_burst_buf #(
    .W  (8),
    .D  (BURST_MAX),
    .AW (BIDX_W)
  ) u_buf (
    .clk_sys  (clk_sys),
    .wrEn     (rdFire),
    .wrAddr   (idx_q[BIDX_W-1:0]),
    .wrData   (rdData),
    .rdAddr   (bufRa),
    .rdData_q (bufQ)
  );

  // ----------------------------------------------------------------
  // Checksum feed and channel requests
  // ----------------------------------------------------------------

  // Each written byte is offered to the checksum unit
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      crcValid_q <= 1'b0;
      crcData_q  <= '0;
      doneIrq_q  <= '0;
      errIrq_q   <= '0;
    end
    else
    begin
      crcValid_q <= wrFire & cfgA.crcEn;
      crcData_q  <= bufQ;
      for (int i = 0; i < NCH; i++)
      begin
        doneIrq_q[i] <= busy & (ch_q == i) & trEnd & chCfg[i].doneIrqEn;
        errIrq_q[i]  <= busy & (ch_q == i) & busErr & chCfg[i].errIrqEn;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus ports
  // ----------------------------------------------------------------

  // Read and write masters carry their own section, though the engine
  // raises rdReq only in S_READ and wrReq only in S_WRITE, never both in one cycle;
  // any section may be a source or a destination
  assign rdReq    = inRead;
  assign rdAddr   = srcCur[ch_q];
  assign rdSect   = srcSect;
  assign wrReq    = inWrite;
  assign wrAddr   = dstCur[ch_q];
  assign wrSect   = dstSect;
  assign wrData   = bufQ;
  assign crcValid = crcValid_q;
  assign crcData  = crcData_q;
  assign chBusy   = armed;
  assign doneIrq  = doneIrq_q;
  assign errIrq   = errIrq_q;

endmodule : tcde_engine

/* tb/tcde_engine_assertions.sv */
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Port checker for the engine
// ----------------------------------------------------------------
module tcde_engine_assertions
  import tcde_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst_b,
  input wire logic [NCH-1:0]    chStart,
  input wire logic [NCH-1:0]    chBusy,
  input wire logic              rdReq,
  input wire logic [ADDR_W-1:0] rdAddr,
  input wire logic [1:0]        rdSect,
  input wire logic              rdGnt,
  input wire logic              rdErr,
  input wire logic              wrReq,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [1:0]        wrSect,
  input wire logic              wrGnt,
  input wire logic              wrErr,
  input wire logic              crcValid,
  input wire logic [NCH-1:0]    doneIrq,
  input wire logic [NCH-1:0]    errIrq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // Section expected from each address, storage window fixed at its base
  wire [1:0] rdExp = rdAddr < EE_BASE ? SECT_IO : rdAddr < SRAM_BASE ? SECT_EE : rdAddr < SRAM_MID ? SECT_SRLO : SECT_SRHI;
  wire [1:0] wrExp = wrAddr < EE_BASE ? SECT_IO : wrAddr < SRAM_BASE ? SECT_EE : wrAddr < SRAM_MID ? SECT_SRLO : SECT_SRHI;

  // First granted cycles of a fresh SRAM or storage read
  sequence srFirst;
    $rose(rdReq) && rdGnt && rdSect[1];
  endsequence
  sequence eeFirst;
    $rose(rdReq) && rdGnt && rdSect == SECT_EE ##1 rdGnt;
  endsequence

  AST_START_OPENS: assert property ((chStart & ~chBusy) != 0 |=> ($past(chStart & ~chBusy) & ~chBusy) == 0)
    else $error("start did not open channel");
  AST_RD_SECTION: assert property (rdReq |-> rdSect == rdExp)
    else $error("read section wrong");
  AST_WR_SECTION: assert property (wrReq |-> wrSect == wrExp)
    else $error("write section wrong");
  AST_RD_STALL: assert property (rdReq && !rdGnt && !rdErr |=> rdReq && $stable(rdAddr))
    else $error("read lost while stalled");
  AST_WR_STALL: assert property (wrReq && !wrGnt && !wrErr |=> wrReq && $stable(wrAddr))
    else $error("write lost while stalled");
  AST_SR_LATENCY: assert property (srFirst |=> $stable(rdAddr))
    else $error("SRAM first byte too early");
  AST_EE_LATENCY: assert property (eeFirst |=> $stable(rdAddr))
    else $error("storage first byte too early");
  AST_CRC_FEED: assert property (crcValid |-> $past(wrReq && wrGnt))
    else $error("checksum byte without write");
  AST_DONE_CAUSE: assert property (doneIrq != 0 |-> $past(wrReq && wrGnt) ##1 doneIrq == 0)
    else $error("done pulse misplaced");
  AST_ERR_CAUSE: assert property (errIrq != 0 |-> $past(rdReq && rdErr || wrReq && wrErr))
    else $error("error pulse without bus error");
endmodule : tcde_engine_assertions

/* tb/tcde_mem_model.sv */
`timescale 1ns/100ps

// Memory and peripheral side: grants, read pattern, write capture
module tcde_mem_model
  import tcde_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              stallEn,
  input  wire logic              errEn,
  input  wire logic              rdReq,
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic                   rdGnt,
  output logic      [7:0]        rdData,
  output logic                   rdErr,
  input  wire logic              wrReq,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [7:0]        wrData,
  output logic                   wrGnt,
  output logic                   wrErr
);
  logic [7:0] mem [0:65535];    // Captured written bytes
  logic       tick_q  = 1'b0;   // Stall phase
  int         wrCount = 0;      // Granted writes
  wire  [7:0] pat = rdAddr[7:0] ^ rdAddr[15:8];

  // Stalls alternate so each side loses every other cycle
  assign rdGnt  = rdReq && !(stallEn && tick_q);
  assign wrGnt  = wrReq && !(stallEn && !tick_q);
  // Idle bus shows the inverse, never a stale byte
  assign rdData = rdReq ? pat : ~pat;
  assign rdErr  = rdReq && rdGnt && errEn;
  assign wrErr  = 1'b0;

  always @(posedge clk_sys)
  begin
    tick_q <= !tick_q;
    if (wrReq && wrGnt)
    begin
      mem[wrAddr] <= wrData;
      wrCount     <= wrCount + 1;
    end
  end
endmodule : tcde_mem_model

/* tb/tcde_engine_tb.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end

module tcde_engine_tb
  import tcde_pkg::*;
;
  logic                clk_sys = 1'b0, rst_b = 1'b0, prioRr = 1'b0, linkEn = 1'b0;
  logic                stallEn = 1'b0, errEn = 1'b0;
  tcde_cfg_t [NCH-1:0] chCfg = '0;
  logic [NCH-1:0]      chStart = '0, swTrig = '0, perReq = '0, evIn = '0;
  logic                rdReq, rdGnt, rdErr, wrReq, wrGnt, wrErr, crcValid;
  logic [ADDR_W-1:0]   rdAddr, wrAddr;
  logic [1:0]          rdSect, wrSect;
  logic [7:0]          rdData, wrData, crcData;
  logic [NCH-1:0]      chBusy, doneIrq, errIrq;
  int                  mismatches = 0, comparisons = 0, crcCnt, doneCnt, errCnt, w0, n;
  tcde_cfg_t           c;
  logic [7:0]          crcLast;

  always #50 clk_sys = ~clk_sys;

  tcde_engine uut (.clk_sys(clk_sys), .rst_b(rst_b), .chCfg(chCfg), .chStart(chStart), .swTrig(swTrig),
    .perReq(perReq), .evIn(evIn), .prioRr(prioRr), .linkEn(linkEn), .rdReq(rdReq), .rdAddr(rdAddr),
    .rdSect(rdSect), .rdGnt(rdGnt), .rdData(rdData), .rdErr(rdErr), .wrReq(wrReq), .wrAddr(wrAddr),
    .wrSect(wrSect), .wrData(wrData), .wrGnt(wrGnt), .wrErr(wrErr), .crcValid(crcValid),
    .crcData(crcData), .chBusy(chBusy), .doneIrq(doneIrq), .errIrq(errIrq));
  tcde_mem_model mm (.clk_sys(clk_sys), .stallEn(stallEn), .errEn(errEn), .rdReq(rdReq), .rdAddr(rdAddr),
    .rdGnt(rdGnt), .rdData(rdData), .rdErr(rdErr), .wrReq(wrReq), .wrAddr(wrAddr), .wrData(wrData),
    .wrGnt(wrGnt), .wrErr(wrErr));

  // Pulse counters for checksum, done and error outputs
  always @(posedge clk_sys)
  begin
    if (crcValid === 1'b1)
    begin
      crcCnt++;
      crcLast = crcData;
    end
    if (doneIrq !== 2'h0) doneCnt++;
    if (errIrq !== 2'h0) errCnt++;
  end

  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction : pat

  function automatic tcde_cfg_t mk(input logic [15:0] s, d, b, input logic [1:0] sm, dm, bs, tg);
    mk = '0;
    mk.srcStart = s;
    mk.dstStart = d;
    mk.blkSize = b;
    mk.rptCnt = 8'h01;
    mk.srcMode = sm;
    mk.dstMode = dm;
    mk.burstSel = bs;
    mk.trigSel = tg;
  endfunction : mk

  // Open a channel, then pulse its trigger once; a peripheral request is left high
  task automatic run(input int ch, input tcde_cfg_t cf);
    crcCnt = 0;
    doneCnt = 0;
    errCnt = 0;
    w0 = mm.wrCount;
    @(negedge clk_sys);
    chCfg[ch] = cf;
    chStart[ch] = 1'b1;
    @(negedge clk_sys);
    chStart[ch] = 1'b0;
    swTrig[ch] = (cf.trigSel == TRG_SW);
    perReq[ch] = (cf.trigSel == TRG_PER);
    evIn[ch] = (cf.trigSel == TRG_EV);
    @(negedge clk_sys);
    swTrig[ch] = 1'b0;
    evIn[ch] = 1'b0;
  endtask : run

  // Bounded wait for a channel to close
  task automatic idle(input int ch, input string nm);
    n = 0;
    while (chBusy[ch] !== 1'b0 && n < 3000)
    begin
      @(negedge clk_sys);
      n++;
    end
    // Checksum and request pulses rise on the edge that closes the channel and are counted one edge later
    repeat (2) @(negedge clk_sys);
    perReq[ch] = 1'b0;
    `CHK("chBusy", 1'b0, chBusy[ch])
    $display("test %s done", nm);
  endtask : idle

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // Watchdog at 30000 clock cycles, far above the expected run length
  initial
  begin
    #3000000;
    mismatches++;
    give_verdict();
  end

  initial
  begin
    repeat (16) @(negedge clk_sys);
    rst_b = 1'b1;
    // Every burst length, block of 5 so the tail burst is short for lengths 2, 4 and 8
    for (int b = 0; b < 4; b++)
    begin
      c = mk(16'(16'h6000 + 16 * b), 16'(16'h2100 + 16 * b), 16'h0005, AM_INC, AM_INC, 2'(b), TRG_SW);
      c.rptCnt = 8'h02;
      c.crcEn = 1'b1;
      c.doneIrqEn = 1'b1;
      run(0, c);
      idle(0, "bursts");
      for (int k = 0; k < 10; k++) `CHK("data", pat(16'(16'h6000 + 16 * b + k)), mm.mem[16'h2100 + 16 * b + k])
      `CHK("crcCount", 10, crcCnt)
      `CHK("crcData", pat(16'(16'h6009 + 16 * b)), crcLast)
      `CHK("doneCount", 1, doneCnt)
    end
    // Storage source counting down to a fixed I/O place, stalled bus
    stallEn = 1'b1;
    run(1, mk(16'h1003, 16'h0040, 16'h0004, AM_DEC, AM_FIXED, 2'h1, TRG_PER));
    idle(1, "storage");
    stallEn = 1'b0;
    `CHK("ioByte", pat(16'h1000), mm.mem[16'h0040])
    `CHK("writes", 4, mm.wrCount - w0)
    `CHK("doneMasked", 0, doneCnt)
    // Source reloaded after each burst, two event triggers
    c = mk(16'h1010, 16'h2300, 16'h0004, AM_INC, AM_INC, 2'h1, TRG_EV);
    c.srcReload = RL_BURST;
    run(0, c);
    repeat (40) @(negedge clk_sys);
    evIn[0] = 1'b1;
    @(negedge clk_sys);
    evIn[0] = 1'b0;
    idle(0, "reload");
    `CHK("reload", pat(16'h1010), mm.mem[16'h2302])
    `CHK("reload", pat(16'h1011), mm.mem[16'h2303])
    // Bus error aborts with an error pulse only
    errEn = 1'b1;
    c = mk(16'h2000, 16'h2040, 16'h0004, AM_INC, AM_INC, 2'h2, TRG_SW);
    c.errIrqEn = 1'b1;
    c.doneIrqEn = 1'b1;
    run(0, c);
    idle(0, "error");
    errEn = 1'b0;
    `CHK("errCount", 1, errCnt)
    `CHK("doneCount", 0, doneCnt)
    // Linked channels: the end of channel 0 starts channel 1
    chCfg[1] = mk(16'h2600, 16'h2700, 16'h0002, AM_INC, AM_INC, 2'h0, TRG_SW);
    linkEn = 1'b1;
    run(0, mk(16'h2400, 16'h2500, 16'h0002, AM_INC, AM_INC, 2'h0, TRG_SW));
    n = 0;
    while (chBusy[1] !== 1'b1 && n < 500)
    begin
      @(negedge clk_sys);
      n++;
    end
    linkEn = 1'b0;
    idle(1, "link");
    `CHK("linked", pat(16'h2601), mm.mem[16'h2701])
    // Both channels pending at once; alternating grant lets channel 1 in
    // before channel 0 ends, fixed order would not
    prioRr = 1'b1;
    @(negedge clk_sys);
    chCfg[0] = mk(16'h2a00, 16'h2b00, 16'h0002, AM_INC, AM_INC, 2'h0, TRG_SW);
    chCfg[1] = mk(16'h2800, 16'h2900, 16'h0002, AM_INC, AM_INC, 2'h0, TRG_SW);
    chStart = 2'h3;
    @(negedge clk_sys);
    chStart = 2'h0;
    swTrig = 2'h3;
    @(negedge clk_sys);
    swTrig = 2'h0;
    idle(0, "priority");
    `CHK("alternate", pat(16'h2800), mm.mem[16'h2900])
    idle(1, "priority");
    `CHK("alternate", pat(16'h2a01), mm.mem[16'h2b01])
    give_verdict();
  end
endmodule : tcde_engine_tb

bind tcde_engine tcde_engine_assertions chk (.clk_sys(clk_sys), .rst_b(rst_b), .chStart(chStart),
  .chBusy(chBusy), .rdReq(rdReq), .rdAddr(rdAddr), .rdSect(rdSect), .rdGnt(rdGnt), .rdErr(rdErr),
  .wrReq(wrReq), .wrAddr(wrAddr), .wrSect(wrSect), .wrGnt(wrGnt), .wrErr(wrErr), .crcValid(crcValid),
  .doneIrq(doneIrq), .errIrq(errIrq));
